// [design/pcmct_map.svh]
// Constants for the PCM codec timing and companding block
`ifndef PCMCT_MAP_SVH
`define PCMCT_MAP_SVH
`define PCMCT_LIN_W        13
`define PCMCT_PCM_W        8
`define PCMCT_SIGN_BIT     7
`define PCMCT_CHORD_HI     6
`define PCMCT_CHORD_LO     4
`define PCMCT_STEP_HI      3
`define PCMCT_ZERO_SUPP    8'h02
`define PCMCT_ALAW_XOR     8'h55
`define PCMCT_MULAW_XOR    8'h7F
`define PCMCT_SEQ_KHZ      128
`define PCMCT_FRAME_KHZ    8
`define PCMCT_RATIO_128    11'd16
`define PCMCT_RATIO_1536   11'd192
`define PCMCT_RATIO_1544   11'd193
`define PCMCT_RATIO_2048   11'd256
`define PCMCT_RATIO_2560   11'd320
`define PCMCT_DIV_1536     5'd12
`define PCMCT_DIV_2048     5'd16
`define PCMCT_DIV_2560     5'd20
`define PCMCT_FIFO_DEPTH   8
`endif

// [design/pcmct_pkg.sv]
// Types shared by both ends of the PCM codec link
package pcmct_pkg;
  typedef enum logic [1:0] {
    PCMCT_LAW_MU_INV  = 2'h0,
    PCMCT_LAW_MU_SM   = 2'h1,
    PCMCT_LAW_A       = 2'h2
  } pcmct_law_t;
  typedef enum logic [2:0] {
    PCMCT_PRE_NONE = 3'h0,
    PCMCT_PRE_128  = 3'h1,
    PCMCT_PRE_1536 = 3'h2,
    PCMCT_PRE_1544 = 3'h3,
    PCMCT_PRE_2048 = 3'h4,
    PCMCT_PRE_2560 = 3'h5
  } pcmct_pre_t;
  typedef enum logic [1:0] {
    PCMCT_RX_IDLE = 2'b00,
    PCMCT_RX_SHIFT = 2'b01,
    PCMCT_RX_DONE = 2'b11
  } pcmct_rx_t;
endpackage

// [design/pcmct_if.sv]
// Serial PCM highway between codec and highway controller
`timescale 1ns/1ps
interface pcmct_if;
  logic frame_sync_in;
  logic convert_clock_in;
  logic tx_shift_clock;
  logic rx_shift_clock;
  logic shared_data_clock;
  logic tx_word_enable;
  logic rx_word_enable;
  logic tx_serial_out;
  logic tx_serial_oe;
  logic rx_serial_in;
  modport codec (
    input  frame_sync_in, convert_clock_in, tx_shift_clock, rx_shift_clock,
    input  shared_data_clock, tx_word_enable, rx_word_enable, rx_serial_in,
    output tx_serial_out, tx_serial_oe
  );
  modport highway (
    output frame_sync_in, convert_clock_in, tx_shift_clock, rx_shift_clock,
    output shared_data_clock, tx_word_enable, rx_word_enable, rx_serial_in,
    input  tx_serial_out, tx_serial_oe
  );
endinterface

// [design/pcmct_fifo.sv]
// Parameterised valid/ready FIFO for PCM words
`timescale 1ns/1ps
module pcmct_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Handshakes; full and empty follow the occupancy count
  assign in_ready  = (int'(cnt_q) < DEPTH); // Full once DEPTH words are held
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q];

  // Storage writes
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (int'(wr_q) == DEPTH - 1) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (int'(rd_q) == DEPTH - 1) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// [design/pcmct_codec.sv]
// Codec end: companding, prescaler selection and serial PCM ports
//
// How it works
// - Linear 13-bit to 8-bit PCM, both ways
// - Word is sign, three chord, four step
// - Sixteen equal steps inside each chord
// - Steps carry into chord; chords above 1 double step
// - Mu-255 and A law on both directions
// - Three law settings with inversions and suppression
// - Far end drives 8 kHz frame sync
// - Frame sync period picks convert prescaler
// - Prescale to 128 kHz; 128 kHz passes straight
// - Convert clock is one of five rates
// - Slowest convert clock holds 40-60% duty
// - Separate data clocks run 64 kHz-4.096 MHz
// - On the data side frame sync only places the transmit strobe
// - First enable rise after sync loads word
// - Eight receive falls capture, ninth moves word
// - Asynchronous use derives sync from transmit
// - Option ties frame sync to word enable
// - Option feeds convert clock from transmit clock
// - Option shares one data clock both ways
// - Full build allows bit or byte interleave on transmit; receive takes byte interleave only
`timescale 1ns/1ps
module pcmct_codec #(
  parameter bit SYNC_IS_TX_ENABLE = 1'b0,
  parameter bit CONVERT_IS_TX_CLK = 1'b0,
  parameter bit SHARED_DATA_CLK   = 1'b0
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  // Highway link
  pcmct_if.codec                      link,
  // Configuration
  input  wire pcmct_pkg::pcmct_law_t  law_select,
  // Transmit sample from the converter
  input  wire logic [12:0]            tx_linear,
  output logic                        tx_strobe,
  // Receive sample to the converter
  output logic [12:0]                 rx_linear,
  output logic                        rx_linear_valid,
  input  wire logic                   rx_linear_ready,
  // Sequencing
  output logic                        seq_tick,
  output pcmct_pkg::pcmct_pre_t       prescale_sel
);
  import pcmct_pkg::*;
  `include "pcmct_map.svh"

  // Encode: linear two's complement to sign/chord/step
  function automatic logic [7:0] enc_sm(input logic [12:0] lin);
    logic [12:0] full;
    logic [11:0] mag;
    logic [2:0]  chord;
    logic [3:0]  step;
    full  = lin[12] ? 13'(~lin + 13'h0001) : lin;
    mag   = (full > 13'h0FFF) ? 12'hFFF : full[11:0]; // Most negative sample saturates
    chord = 3'h0;
    step  = mag[4:1];
    for (int c = 7; c >= 1; c--) begin
      if (chord == 3'h0 && mag[c+4]) begin
        chord = 3'(c);
        step  = 4'(mag >> c);
      end
    end
    return {~lin[12], chord, step};
  endfunction

  // Decode: sign/chord/step back to linear midpoint
  function automatic logic [12:0] dec_sm(input logic [7:0] w);
    logic [11:0] mag;
    mag = (w[6:4] == 3'h0) ? {7'h00, w[3:0], 1'b1}
                           : 12'(({7'h01, w[3:0], 1'b1}) << (w[6:4] - 3'h1));
    return w[7] ? {1'b0, mag} : 13'(~{1'b0, mag} + 13'h0001);
  endfunction

  // Law formatting applied to sign-magnitude words, both ways
  function automatic logic [7:0] fmt(input logic [7:0] sm, input pcmct_law_t law, input logic tx);
    logic [7:0] w;
    case (law)
      PCMCT_LAW_MU_INV: begin
        w = sm ^ `PCMCT_MULAW_XOR;
        if (tx && w == 8'h00) begin
          w = `PCMCT_ZERO_SUPP;
        end
      end
      PCMCT_LAW_A:  w = sm ^ `PCMCT_ALAW_XOR;
      default:      w = sm;
    endcase
    return w;
  endfunction

  // Clock selection for the build options
  logic tx_clk_src, rx_clk_src, cv_clk_src, sync_src;
  assign tx_clk_src = SHARED_DATA_CLK ? link.shared_data_clock : link.tx_shift_clock;
  assign rx_clk_src = SHARED_DATA_CLK ? link.shared_data_clock : link.rx_shift_clock;
  assign cv_clk_src = CONVERT_IS_TX_CLK ? tx_clk_src : link.convert_clock_in;
  assign sync_src   = SYNC_IS_TX_ENABLE ? link.tx_word_enable : link.frame_sync_in;

  // Edge detection on the sampled pins
  logic txc_q, rxc_q, cvc_q, syn_q, tde_q, rce_q, rxd_q; // Data kept with the clock level it arrived under
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {txc_q, rxc_q, cvc_q, syn_q, tde_q, rce_q, rxd_q} <= 7'h00;
    end else begin
      {txc_q, rxc_q, cvc_q, syn_q, tde_q, rce_q, rxd_q} <= {tx_clk_src, rx_clk_src, cv_clk_src, sync_src,
        link.tx_word_enable, link.rx_word_enable, link.rx_serial_in};
    end
  end
  logic txc_rise, rxc_fall, cvc_rise, syn_rise, tde_rise, rce_rise;
  assign txc_rise = tx_clk_src & ~txc_q;
  assign rxc_fall = ~rx_clk_src & rxc_q;
  assign cvc_rise = cv_clk_src & ~cvc_q;
  assign syn_rise = sync_src & ~syn_q;
  assign tde_rise = link.tx_word_enable & ~tde_q;
  assign rce_rise = link.rx_word_enable & ~rce_q;

  // Convert cycles per frame pick the divider; odd rates stay on last good choice
  logic [10:0] cv_cnt_q;
  pcmct_pre_t  pre_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cv_cnt_q <= 11'h000;
      pre_q    <= PCMCT_PRE_NONE;
    end else if (syn_rise) begin
      cv_cnt_q <= {10'h000, cvc_rise};
      case (cv_cnt_q)
        `PCMCT_RATIO_128:  pre_q <= PCMCT_PRE_128;
        `PCMCT_RATIO_1536: pre_q <= PCMCT_PRE_1536;
        `PCMCT_RATIO_1544: pre_q <= PCMCT_PRE_1544;
        `PCMCT_RATIO_2048: pre_q <= PCMCT_PRE_2048;
        `PCMCT_RATIO_2560: pre_q <= PCMCT_PRE_2560;
        default:           pre_q <= pre_q;
      endcase
    end else if (cvc_rise && cv_cnt_q != 11'h7FF) begin
      cv_cnt_q <= cv_cnt_q + 11'h001;
    end
  end
  assign prescale_sel = pre_q;

  // Prescaler to the 128 kHz sequencing tick; 1.544 MHz drops one cycle per frame
  logic [4:0] pre_cnt_q;
  logic [4:0] pre_div;
  logic       seq_q;
  always_comb begin
    case (pre_q)
      PCMCT_PRE_1536, PCMCT_PRE_1544: pre_div = `PCMCT_DIV_1536;
      PCMCT_PRE_2048:                 pre_div = `PCMCT_DIV_2048;
      PCMCT_PRE_2560:                 pre_div = `PCMCT_DIV_2560;
      default:                        pre_div = 5'h01;
    endcase
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt_q <= 5'h00;
      seq_q     <= 1'b0;
    end else begin
      seq_q <= 1'b0;
      if (syn_rise) begin
        // A convert edge on the frame edge opens the new frame; 128 kHz ticks straight through
        pre_cnt_q <= (cvc_rise && pre_div != 5'h01) ? 5'h01 : 5'h00;
        seq_q     <= cvc_rise && pre_q != PCMCT_PRE_NONE && pre_div == 5'h01;
      end else if (cvc_rise && pre_q != PCMCT_PRE_NONE) begin
        if (pre_cnt_q + 5'h01 >= pre_div) begin
          pre_cnt_q <= 5'h00;
          seq_q     <= 1'b1;
        end else begin
          pre_cnt_q <= pre_cnt_q + 5'h01;
        end
      end
    end
  end
  assign seq_tick = seq_q;

  // Transmit: strobe armed by frame sync, fired by next enable rise
  logic       armed_q, strobe_q;
  logic [7:0] tx_sr_q;
  logic       tx_bit_q;
  logic [7:0] tx_word;
  assign tx_word = fmt(enc_sm(tx_linear), law_select, 1'b1);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      armed_q  <= 1'b0;
      strobe_q <= 1'b0;
      tx_sr_q  <= 8'h00;
      tx_bit_q <= 1'b0;
    end else begin
      strobe_q <= 1'b0;
      if (syn_rise) begin
        armed_q <= 1'b1;
      end
      if (tde_rise && (armed_q || syn_rise)) begin
        armed_q  <= 1'b0;
        strobe_q <= 1'b1;
        tx_sr_q  <= tx_word;
        tx_bit_q <= tx_word[7];
      end else if (link.tx_word_enable && txc_rise) begin
        // First rise repeats the sign; the word rotates so it may be read again, and gating allows bit interleave
        tx_bit_q <= tx_sr_q[7];
        tx_sr_q  <= {tx_sr_q[6:0], tx_sr_q[7]};
      end
    end
  end
  assign tx_strobe          = strobe_q;
  assign link.tx_serial_out = tx_bit_q;
  assign link.tx_serial_oe  = link.tx_word_enable;

  // Receive shifter
  pcmct_rx_t  rx_st_q;
  logic [3:0] rx_cnt_q;
  logic [7:0] rx_sr_q;
  logic       rx_push;
  logic [7:0] rx_word_q;
  logic       rx_ready;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_st_q   <= PCMCT_RX_IDLE;
      rx_cnt_q  <= 4'h0;
      rx_sr_q   <= 8'h00;
      rx_word_q <= 8'h00;
    end else begin
      case (rx_st_q)
        PCMCT_RX_IDLE: begin
          if (rce_rise) begin
            rx_st_q  <= PCMCT_RX_SHIFT;
            rx_cnt_q <= 4'h0;
          end
        end
        PCMCT_RX_SHIFT: begin
          if (rxc_fall) begin
            if (rx_cnt_q == 4'h8) begin
              rx_word_q <= fmt(rx_sr_q, law_select, 1'b0);
              rx_st_q   <= PCMCT_RX_DONE;
            end else begin
              rx_sr_q  <= {rx_sr_q[6:0], rxd_q};
              rx_cnt_q <= rx_cnt_q + 4'h1;
            end
          end
        end
        PCMCT_RX_DONE: begin
          if (rx_ready) begin
            rx_st_q <= PCMCT_RX_IDLE;
          end
        end
        default: rx_st_q <= PCMCT_RX_IDLE;
      endcase
    end
  end
  assign rx_push = (rx_st_q == PCMCT_RX_DONE);

  // Decode buffer; a stalled converter holds the shifter in its done state
  logic [7:0] fifo_word;
  pcmct_fifo #(.WIDTH(8), .DEPTH(`PCMCT_FIFO_DEPTH)) u_rx_buf (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .in_valid  (rx_push),
    .in_ready  (rx_ready),
    .in_data   (rx_word_q),
    .out_valid (rx_linear_valid),
    .out_ready (rx_linear_ready),
    .out_data  (fifo_word)
  );
  assign rx_linear = dec_sm(fifo_word);
endmodule

// [design/pcmct_highway.sv]
// Highway controller end: makes frame sync, clocks and serial words
`timescale 1ns/1ps
`include "pcmct_map.svh"
module pcmct_highway #(
  parameter int unsigned CONV_DIV = `PCMCT_DIV_2048,
  parameter int unsigned DATA_DIV = 4,
  parameter int unsigned FRAME_CONV = 256
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Highway link
  pcmct_if.highway        link,
  // User words
  input  wire logic [7:0] send_word,
  output logic [7:0]      recv_word,
  output logic            recv_valid
);
  import pcmct_pkg::*;

  // Convert clock divider; half-period toggling gives 50% duty
  logic [7:0]  cdiv_q, ddiv_q;
  logic        cclk_q, dclk_q;
  logic [10:0] fr_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cdiv_q <= 8'h00;
      cclk_q <= 1'b0;
      fr_q   <= 11'(FRAME_CONV - 1); // First convert rise opens a full frame, no short one after reset
    end else if (cdiv_q == 8'(CONV_DIV / 2 - 1)) begin
      cdiv_q <= 8'h00;
      cclk_q <= ~cclk_q;
      if (!cclk_q) begin
        fr_q <= (fr_q == 11'(FRAME_CONV - 1)) ? 11'h000 : fr_q + 11'h001;
      end
    end else begin
      cdiv_q <= cdiv_q + 8'h01;
    end
  end

  // Data clock divider
  logic dclk_fall;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ddiv_q <= 8'h00;
      dclk_q <= 1'b0;
    end else if (ddiv_q == 8'(DATA_DIV / 2 - 1)) begin
      ddiv_q <= 8'h00;
      dclk_q <= ~dclk_q;
    end else begin
      ddiv_q <= ddiv_q + 8'h01;
    end
  end
  assign dclk_fall = dclk_q && ddiv_q == 8'(DATA_DIV / 2 - 1);

  // Byte slot: enables high for eight data clocks after each frame start
  logic       frame_pend_q, slot_q;
  logic [3:0] bit_q;
  logic [7:0] rx_sr_q, tx_sr_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      frame_pend_q <= 1'b0;
      slot_q       <= 1'b0;
      bit_q        <= 4'h0;
      rx_sr_q      <= 8'h00;
      tx_sr_q      <= 8'h00;
      recv_word    <= 8'h00;
      recv_valid   <= 1'b0;
    end else begin
      recv_valid <= 1'b0;
      if (fr_q == 11'h000 && cdiv_q == 8'h00 && cclk_q) begin
        frame_pend_q <= 1'b1;
      end
      if (dclk_fall) begin
        if (frame_pend_q && !slot_q) begin
          frame_pend_q <= 1'b0;
          slot_q       <= 1'b1;
          bit_q        <= 4'h0;
          tx_sr_q      <= send_word;
        end else if (slot_q) begin
          rx_sr_q <= {rx_sr_q[6:0], link.tx_serial_out};
          tx_sr_q <= {tx_sr_q[6:0], 1'b0};
          bit_q   <= bit_q + 4'h1;
          if (bit_q == 4'h7) begin
            slot_q     <= 1'b0;
            recv_word  <= {rx_sr_q[6:0], link.tx_serial_out};
            recv_valid <= 1'b1;
          end
        end
      end
    end
  end

  // Link drives; frame sync is high for the first half of each frame
  assign link.convert_clock_in  = cclk_q;
  assign link.frame_sync_in     = (fr_q < 11'(FRAME_CONV / 2));
  assign link.tx_shift_clock    = dclk_q;
  assign link.rx_shift_clock    = dclk_q;
  assign link.shared_data_clock = dclk_q;
  assign link.tx_word_enable    = slot_q;
  assign link.rx_word_enable    = slot_q;
  assign link.rx_serial_in      = tx_sr_q[7];
endmodule

// [sim/pcmct_props.sv]
// Checker for the serial PCM highway between codec and highway ends
`timescale 1ns/1ps
module pcmct_props #(
  parameter int unsigned CONV_DIV   = 4,
  parameter int unsigned FRAME_CONV = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Highway pins
  input wire logic frame_sync_in,
  input wire logic convert_clock_in,
  input wire logic tx_shift_clock,
  input wire logic rx_shift_clock,
  input wire logic tx_word_enable,
  input wire logic rx_word_enable,
  input wire logic tx_serial_out,
  input wire logic tx_serial_oe
);
  logic        cc_q, fs_q, tc_q, te_q, rc_q, re_q;
  logic        cv_arm_q, fs_arm_q;
  logic [15:0] per_q, hi_q, frm_q;
  logic [3:0]  bits_q, since_q;
  logic        cv_rise, cv_fall, fs_rise, tc_rise, te_rise, te_fall, rc_rise, re_rise;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // Edges seen as level changes between samples
  assign cv_rise = convert_clock_in & ~cc_q;
  assign cv_fall = ~convert_clock_in & cc_q;
  assign fs_rise = frame_sync_in & ~fs_q;
  assign tc_rise = tx_shift_clock & ~tc_q;
  assign te_rise = tx_word_enable & ~te_q;
  assign te_fall = ~tx_word_enable & te_q;
  assign rc_rise = rx_shift_clock & ~rc_q;
  assign re_rise = rx_word_enable & ~re_q;

  // Previous pin levels
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {cc_q, fs_q, tc_q, te_q, rc_q, re_q} <= 6'h00;
    end else begin
      {cc_q, fs_q, tc_q, te_q, rc_q, re_q} <= {convert_clock_in, frame_sync_in, tx_shift_clock,
                                               tx_word_enable, rx_shift_clock, rx_word_enable};
    end
  end

  // Period, high time and frame counts; arming skips the partial first period after reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {cv_arm_q, fs_arm_q} <= 2'h0;
      per_q                <= 16'h0000;
      hi_q                 <= 16'h0000;
      frm_q                <= 16'h0000;
    end else begin
      cv_arm_q <= cv_arm_q | cv_rise;
      fs_arm_q <= fs_arm_q | fs_rise;
      per_q    <= cv_rise ? 16'h0001 : per_q + 16'h0001;
      hi_q     <= cv_rise ? 16'h0001 : (convert_clock_in ? hi_q + 16'h0001 : hi_q);
      if (fs_rise) frm_q <= {15'h0000, cv_rise};
      else if (cv_rise) frm_q <= frm_q + 16'h0001;
    end
  end

  // Bits shifted per enable window and cycles since the last transmit edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bits_q  <= 4'h0;
      since_q <= 4'h0;
    end else begin
      if (te_rise) bits_q <= 4'h0;
      else if (tc_rise && tx_word_enable && bits_q != 4'hF) bits_q <= bits_q + 4'h1;
      if (tc_rise || te_rise) since_q <= 4'h0;
      else if (since_q != 4'hF) since_q <= since_q + 4'h1;
    end
  end

  property p_oe_follows_enable;
    tx_serial_oe == tx_word_enable;
  endproperty
  a_oe_follows_enable: assert property (p_oe_follows_enable) else $error("output enable not tied to word enable");

  property p_tx_bit_timing;
    $changed(tx_serial_out) |-> since_q <= 4'h2;
  endproperty
  a_tx_bit_timing: assert property (p_tx_bit_timing) else $error("serial out moved without a transmit edge");

  property p_convert_period;
    cv_rise && cv_arm_q |-> per_q == 16'(CONV_DIV);
  endproperty
  a_convert_period: assert property (p_convert_period) else $error("convert clock period wrong");

  property p_convert_duty;
    cv_fall && cv_arm_q |-> hi_q * 10 >= 4 * CONV_DIV && hi_q * 10 <= 6 * CONV_DIV;
  endproperty
  a_convert_duty: assert property (p_convert_duty) else $error("convert clock duty out of range");

  property p_frame_length;
    fs_rise && fs_arm_q |-> frm_q == 16'(FRAME_CONV);
  endproperty
  a_frame_length: assert property (p_frame_length) else $error("frame sync period wrong");

  property p_word_bits;
    te_fall |-> bits_q == 4'h8;
  endproperty
  a_word_bits: assert property (p_word_bits) else $error("enable window not eight bits");

  property p_tx_clk_rate;
    tc_rise |=> !tc_rise [*2];
  endproperty
  a_tx_clk_rate: assert property (p_tx_clk_rate) else $error("transmit data clock too fast");

  property p_rx_clk_rate;
    rc_rise |=> !rc_rise [*2];
  endproperty
  a_rx_clk_rate: assert property (p_rx_clk_rate) else $error("receive data clock too fast");

  // Main traffic seen
  c_frame: cover property (fs_rise && fs_arm_q);
  c_tx_word: cover property (te_fall);
  c_rx_word: cover property (re_rise);
endmodule

// [sim/tb.sv]
// Self-checking bench joining codec and highway ends
`timescale 1ns/1ps
module tb;
  import pcmct_pkg::*;
  localparam int FRAME_CYC = 64;
  localparam logic [12:0] CORNER [6] = '{13'h0FFF, 13'h1000, 13'h0000, 13'h0001, 13'h001F, 13'h0020};
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  pcmct_law_t  law_select = PCMCT_LAW_MU_INV;
  logic [12:0] tx_linear = 13'h0000;
  logic        rx_linear_ready = 1'b1;
  logic [7:0]  send_word = 8'h80;
  logic        tx_strobe, rx_linear_valid, seq_tick, recv_valid;
  logic [12:0] rx_linear, last_rx;
  logic [7:0]  recv_word, last_word;
  pcmct_pre_t  prescale_sel;
  pcmct_pre_t  prescale_sel2;
  logic        recv_valid2, rx_valid2;
  logic [12:0] rx_linear2, last_rx2;
  logic [7:0]  recv_word2, last_word2;
  int          fail_count = 0;
  int          total_checks = 0;
  int          pops = 0;
  int          ticks = 0;
  int          strobes = 0;

  pcmct_if link ();
  pcmct_if link2 ();
  // Free-running 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  pcmct_codec pcmct_codec_i (.sys_clk(sys_clk), .resetn(resetn), .link(link), .law_select(law_select),
    .tx_linear(tx_linear), .tx_strobe(tx_strobe), .rx_linear(rx_linear), .rx_linear_valid(rx_linear_valid),
    .rx_linear_ready(rx_linear_ready), .seq_tick(seq_tick), .prescale_sel(prescale_sel));
  // Short frame keeps the run small: 16 convert cycles of 4 clocks, read as the 128 kHz rate
  pcmct_highway #(.CONV_DIV(4), .DATA_DIV(4), .FRAME_CONV(16)) pcmct_highway_i (.sys_clk(sys_clk),
    .resetn(resetn), .link(link), .send_word(send_word), .recv_word(recv_word), .recv_valid(recv_valid));
  // Second pair runs every build option: sync from enable, one shared data clock, convert from data clock
  pcmct_codec #(.SYNC_IS_TX_ENABLE(1'b1), .CONVERT_IS_TX_CLK(1'b1), .SHARED_DATA_CLK(1'b1)) pcmct_codec_opt_i (
    .sys_clk(sys_clk), .resetn(resetn), .link(link2), .law_select(law_select), .tx_linear(tx_linear),
    .tx_strobe(), .rx_linear(rx_linear2), .rx_linear_valid(rx_valid2), .rx_linear_ready(rx_linear_ready),
    .seq_tick(), .prescale_sel(prescale_sel2));
  pcmct_highway #(.CONV_DIV(4), .DATA_DIV(4), .FRAME_CONV(16)) pcmct_highway_opt_i (.sys_clk(sys_clk),
    .resetn(resetn), .link(link2), .send_word(send_word), .recv_word(recv_word2), .recv_valid(recv_valid2));
  pcmct_props #(.CONV_DIV(4), .FRAME_CONV(16)) pcmct_props_i (.sys_clk(sys_clk), .resetn(resetn),
    .frame_sync_in(link.frame_sync_in), .convert_clock_in(link.convert_clock_in),
    .tx_shift_clock(link.tx_shift_clock), .rx_shift_clock(link.rx_shift_clock),
    .tx_word_enable(link.tx_word_enable), .rx_word_enable(link.rx_word_enable),
    .tx_serial_out(link.tx_serial_out), .tx_serial_oe(link.tx_serial_oe));

  // Linear to sign-magnitude: chord 0 and chord 1 steps weigh 2, each chord above 1 doubles the step
  function automatic logic [7:0] enc_sm(input logic [12:0] lin);
    logic [12:0] mag;
    logic [2:0]  ch;
    mag = lin[12] ? (~lin + 13'h0001) : lin;
    if (mag > 13'h0FFF) mag = 13'h0FFF;
    ch = 3'h0;
    for (int b = 5; b <= 11; b++) if (mag[b]) ch = 3'(b - 4);
    return {~lin[12], ch, (ch == 3'h0) ? mag[4:1] : 4'(mag >> ch)};
  endfunction

  // Line format inversions; self-inverse, so it also undoes them
  function automatic logic [7:0] xlaw(input logic [7:0] w, input pcmct_law_t law);
    return (law == PCMCT_LAW_A) ? w ^ 8'h55 : (law == PCMCT_LAW_MU_INV) ? w ^ 8'h7F : w;
  endfunction

  task automatic chk_word(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      fail_count++;
      $display("Error at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Results leaving both ends
  always @(posedge sys_clk) begin
    if (recv_valid === 1'b1) last_word <= recv_word;
    if (recv_valid2 === 1'b1) last_word2 <= recv_word2;
    if (rx_valid2 === 1'b1 && rx_linear_ready) last_rx2 <= rx_linear2;
    if (rx_linear_valid === 1'b1 && rx_linear_ready) begin
      last_rx <= rx_linear;
      pops++;
    end
    if (seq_tick === 1'b1) ticks++;
    if (tx_strobe === 1'b1) strobes++;
  end

  // One sample each way; four frames let a law change settle before the words are judged
  task automatic run_vec(input pcmct_law_t law, input logic [12:0] lin, input logic [7:0] sm);
    logic [7:0] e;
    law_select <= law;
    tx_linear  <= lin;
    send_word  <= xlaw(sm, law);
    repeat (4 * FRAME_CYC) @(posedge sys_clk);
    e = xlaw(enc_sm(lin), law);
    if (law == PCMCT_LAW_MU_INV && e == 8'h00) e = 8'h02;
    chk_word(last_word, e);
    chk_word(enc_sm(last_rx), sm);
    chk_word(last_word2, e);
    chk_word(enc_sm(last_rx2), sm);
  endtask

  initial begin
    logic [7:0] sm;
    int t0, s0;
    void'($urandom(32'h03CB));
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int l = 0; l < 3; l++) begin
      for (int v = 0; v < 20; v++) begin
        sm = 8'($urandom);
        // Negative zero is sent as positive zero instead, so it is kept off the line
        if (sm[6:0] == 7'h00) sm[7] = 1'b1;
        run_vec(pcmct_law_t'(l), (v < 6) ? CORNER[v] : 13'($urandom), sm);
      end
    end
    chk_word({5'h00, prescale_sel}, {5'h00, PCMCT_PRE_128});
    chk_word({5'h00, prescale_sel2}, {5'h00, PCMCT_PRE_128});
    @(negedge sys_clk);
    t0 = ticks;
    s0 = strobes;
    repeat (4 * FRAME_CYC) @(negedge sys_clk);
    chk_cnt(ticks - t0, 4 * 16);
    chk_cnt(strobes - s0, 4);
    // Fill the buffer with the far side stalled, then drain it
    @(posedge sys_clk);
    rx_linear_ready <= 1'b0;
    repeat (12 * FRAME_CYC) @(posedge sys_clk);
    chk_word({7'h00, rx_linear_valid}, 8'h01);
    t0 = pops;
    rx_linear_ready <= 1'b1;
    repeat (14) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_cnt(pops - t0, 9);
    chk_word({7'h00, rx_linear_valid}, 8'h00);
    final_report();
  end

  // Watchdog well beyond the planned run
  initial begin
    repeat (30000) @(posedge sys_clk);
    fail_count++;
    final_report();
  end
endmodule
